// File: include/lvrf_pkg.sv
// package for the low-voltage reset filter: register map, field layout, filter counts.
// assumes a 125 MHz reference clock and a 32-bit avalon-mm byte-addressed slave port.
package lvrf_pkg;
  // bus geometry
  localparam int          ADDR_W           = 18;
  localparam int          DATA_W           = 32;
  // printed register index, byte address is four times it
  localparam logic [15:0] LV_STATUS_INDEX  = 16'hfe0f;
  localparam logic [17:0] LV_STATUS_ADDR   = {LV_STATUS_INDEX, 2'b00};
  localparam logic [17:0] EVT_STATUS_ADDR  = 18'h00000;
  localparam logic [17:0] EVT_MASK_ADDR    = 18'h00004;
  // field positions
  localparam int          LV_FLAG_BIT      = 7;
  localparam int          EVT_FLAG_BIT     = 0;
  localparam int          EVT_RESET_BIT    = 1;
  localparam int          EVT_W            = 2;
  // reset values
  localparam logic [1:0]  EVT_MASK_RST     = 2'h0;
  localparam logic [31:0] UNMAPPED_DATA    = 32'h00000000;
  // filter counts
  localparam int          RESET_RUN_CYCLES = 9;
  localparam int          FLAG_MIN_XTAL    = 32;
  localparam int          FLAG_MAX_XTAL    = 40;
  localparam int          FLAG_SET_XTAL    = (FLAG_MIN_XTAL + FLAG_MAX_XTAL) / 2;
  // bus slave states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } lvrf_bus_state_t;
endpackage : lvrf_pkg

// File: hdl/lvrf_run_filter.sv
// consecutive-sample run filter: counts qualifying ticks while a condition holds.
// assumes tick and condition are synchronous single-clock inputs.
module lvrf_run_filter #(
  parameter int THRESH = 9,
  parameter int CNT_W  = 6
) (
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  input  wire logic i_clear,
  input  wire logic i_tick,
  input  wire logic i_cond,
  output logic      o_hit
);
  import lvrf_pkg::*;

  localparam logic [CNT_W-1:0] THRESH_C = CNT_W'(THRESH);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  // any broken sample restarts the run; saturates so the hit stays up
  always_comb begin
    cnt_d = cnt_q;
    if (i_clear || !i_cond) begin
      cnt_d = '0;
    end else if (i_tick && cnt_q != THRESH_C) begin
      cnt_d = cnt_q + CNT_W'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign o_hit = (cnt_q == THRESH_C);
endmodule // lvrf_run_filter

// File: hdl/lvrf_evt_regs.sv
// sticky event status with write-one-to-clear, a mask and one level interrupt.
// assumes write strobes are single-cycle and already decoded.
module lvrf_evt_regs #(
  parameter int W = 2
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  input  wire logic [W-1:0] i_event,
  input  wire logic         i_wr_status,
  input  wire logic         i_wr_mask,
  input  wire logic [W-1:0] i_wdata,
  output logic      [W-1:0] o_status,
  output logic      [W-1:0] o_mask,
  output logic              o_irq
);
  import lvrf_pkg::*;

  logic [W-1:0] sts_q;
  logic [W-1:0] sts_d;
  logic [W-1:0] msk_q;
  logic [W-1:0] msk_d;
  logic         irq_q;
  logic         irq_d;

  // set beats clear so an event in the clearing cycle is kept
  always_comb begin
    sts_d = sts_q;
    msk_d = msk_q;
    if (i_wr_status) begin
      sts_d = sts_q & ~i_wdata;
    end
    sts_d = sts_d | i_event;
    if (i_wr_mask) begin
      msk_d = i_wdata;
    end
    irq_d = |(sts_d & msk_d);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      sts_q <= '0;
      msk_q <= EVT_MASK_RST;
      irq_q <= 1'b0;
    end else begin
      sts_q <= sts_d;
      msk_q <= msk_d;
      irq_q <= irq_d;
    end
  end

  assign o_status = sts_q;
  assign o_mask   = msk_q;
  assign o_irq    = irq_q;
endmodule // lvrf_evt_regs

// File: hdl/lvrf_top.sv
// low-voltage reset filter: digital side of a supply monitor with avalon-mm status access.
// assumes comparator, option bits, mode strobes and the crystal clock level are synchronous
// to I_REF_CLK; the crystal clock is sampled as a level, so it must be below half the rate.
//
// Register access over Avalon-MM was decided locally.
module lvrf_top (
  input  wire logic                          I_REF_CLK,
  input  wire logic                          I_RST_B,
  // comparator and option inputs
  input  wire logic                          I_BELOW_FALLING_TRIP,
  input  wire logic                          I_ABOVE_RISING_TRIP,
  input  wire logic                          I_MONITOR_POWER_ENABLE,
  input  wire logic                          I_LOWVOLT_RESET_ENABLE,
  input  wire logic                          I_STOP_MODE_MONITOR_ENABLE,
  input  wire logic                          I_WAIT_MODE,
  input  wire logic                          I_STOP_MODE,
  input  wire logic                          I_CPU_CYCLE,
  input  wire logic                          I_CRYSTAL_CLOCK,
  // avalon-mm slave
  input  wire logic [lvrf_pkg::ADDR_W-1:0]   I_AVS_ADDRESS,
  input  wire logic                          I_AVS_READ,
  input  wire logic                          I_AVS_WRITE,
  input  wire logic [lvrf_pkg::DATA_W-1:0]   I_AVS_WRITEDATA,
  output logic      [lvrf_pkg::DATA_W-1:0]   O_AVS_READDATA,
  output logic                               O_AVS_WAITREQUEST,
  // reset and event interrupt outputs
  output logic                               O_LOWVOLT_RESET,
  output logic                               O_RST_PIN_OUT,
  output logic                               O_RST_PIN_OE,
  output logic                               O_EVT_IRQ
);
  import lvrf_pkg::*;

  // monitor state
  logic                    lv_rst_q;
  logic                    lv_rst_d;
  logic                    flag_q;
  logic                    flag_d;
  logic                    pin_oe_q;
  logic                    xtal_prev_q;
  logic                    xtal_tick;
  logic                    active;
  logic                    stop_trip;
  logic                    rst_hit;
  logic                    flag_hit;
  logic                    rst_release;
  // bus state
  lvrf_bus_state_t         bus_q;
  lvrf_bus_state_t         bus_d;
  logic [DATA_W-1:0]       rdata_q;
  logic [DATA_W-1:0]       rdata_d;
  logic                    wreq_q;
  logic                    wreq_d;
  logic                    take;
  logic                    wr_status;
  logic                    wr_mask;
  logic [EVT_W-1:0]        evt_status;
  logic [EVT_W-1:0]        evt_mask;
  logic [EVT_W-1:0]        events;

  // monitor runs out of reset; only the power option and stop mode gate it
  // wait mode is deliberately not a term here, so the monitor keeps running in wait
  always_comb begin
    active = I_MONITOR_POWER_ENABLE
           && !(I_STOP_MODE && !I_STOP_MODE_MONITOR_ENABLE);
  end

  // crystal clock sampled as a level; rising edge gives one tick
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_B) begin
      xtal_prev_q <= 1'b0;
    end else begin
      xtal_prev_q <= I_CRYSTAL_CLOCK;
    end
  end
  assign xtal_tick = I_CRYSTAL_CLOCK && !xtal_prev_q;

  // cpu-cycle run filter for the forced reset
  lvrf_run_filter #(
    .THRESH (RESET_RUN_CYCLES),
    .CNT_W  (4)
  ) u_rst_filt (
    .i_clk   (I_REF_CLK),
    .i_rst_b (I_RST_B),
    .i_clear (!active || lv_rst_q),
    .i_tick  (I_CPU_CYCLE),
    .i_cond  (I_BELOW_FALLING_TRIP),
    .o_hit   (rst_hit)
  );

  // crystal-cycle run filter for the status flag; sets mid-window
  lvrf_run_filter #(
    .THRESH (FLAG_SET_XTAL),
    .CNT_W  (6)
  ) u_flag_filt (
    .i_clk   (I_REF_CLK),
    .i_rst_b (I_RST_B),
    .i_clear (!active),
    .i_tick  (xtal_tick),
    .i_cond  (I_BELOW_FALLING_TRIP),
    .o_hit   (flag_hit)
  );

  // cpu clocks are off in stop, so a monitored trip there skips the filter
  assign stop_trip   = I_STOP_MODE && I_STOP_MODE_MONITOR_ENABLE && I_BELOW_FALLING_TRIP;
  assign rst_release = I_CPU_CYCLE && I_ABOVE_RISING_TRIP;

  // forced reset: enter on filtered or bypassed trip, leave after one good cycle
  always_comb begin
    lv_rst_d = lv_rst_q;
    if (!I_MONITOR_POWER_ENABLE) begin
      lv_rst_d = 1'b0;
    end else if (lv_rst_q) begin
      if (rst_release) begin
        lv_rst_d = 1'b0;
      end
    end else if (I_LOWVOLT_RESET_ENABLE && active) begin
      if (rst_hit || stop_trip) begin
        lv_rst_d = 1'b1;
      end
    end
  end

  // status flag: set after the filtered run, clear above rising, hold between
  always_comb begin
    flag_d = flag_q;
    if (!active || lv_rst_q) begin
      flag_d = 1'b0;
    end else if (I_ABOVE_RISING_TRIP) begin
      flag_d = 1'b0;
    end else if (flag_hit) begin
      flag_d = 1'b1;
    end
  end

  // reset state and pin drive; the pin pulls low only while the reset stands
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_B) begin
      lv_rst_q <= 1'b0;
      flag_q   <= 1'b0;
      pin_oe_q <= 1'b0;
    end else begin
      lv_rst_q <= lv_rst_d;
      flag_q   <= flag_d;
      pin_oe_q <= lv_rst_d;
    end
  end

  // bus slave: one answer cycle per request, then back to waiting
  always_comb begin
    bus_d   = bus_q;
    rdata_d = rdata_q;
    wreq_d  = 1'b1;
    take    = 1'b0;
    case (bus_q)
      BUS_IDLE: begin
        if (I_AVS_READ || I_AVS_WRITE) begin
          take   = 1'b1;
          bus_d  = BUS_ACK;
          wreq_d = 1'b0;
        end
      end
      BUS_ACK: begin
        bus_d = BUS_IDLE;
      end
      default: begin
        bus_d = BUS_IDLE;
      end
    endcase
    // read data decode
    if (take && I_AVS_READ) begin
      if (I_AVS_ADDRESS == LV_STATUS_ADDR) begin
        rdata_d = UNMAPPED_DATA;
        rdata_d[LV_FLAG_BIT] = flag_q;
      end else if (I_AVS_ADDRESS == EVT_STATUS_ADDR) begin
        rdata_d = {{(DATA_W-EVT_W){1'b0}}, evt_status};
      end else if (I_AVS_ADDRESS == EVT_MASK_ADDR) begin
        rdata_d = {{(DATA_W-EVT_W){1'b0}}, evt_mask};
      end else begin
        rdata_d = UNMAPPED_DATA;
      end
    end
  end

  // writes land at the answer edge; the low-voltage status word is read only
  assign wr_status = (bus_q == BUS_ACK) && I_AVS_WRITE && (I_AVS_ADDRESS == EVT_STATUS_ADDR);
  assign wr_mask   = (bus_q == BUS_ACK) && I_AVS_WRITE && (I_AVS_ADDRESS == EVT_MASK_ADDR);

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_B) begin
      bus_q   <= BUS_IDLE;
      rdata_q <= UNMAPPED_DATA;
      wreq_q  <= 1'b1;
    end else begin
      bus_q   <= bus_d;
      rdata_q <= rdata_d;
      wreq_q  <= wreq_d;
    end
  end

  // system events only; nothing here feeds the cpu interrupt controller
  assign events[EVT_FLAG_BIT]  = flag_d && !flag_q;
  assign events[EVT_RESET_BIT] = lv_rst_d && !lv_rst_q;

  lvrf_evt_regs #(
    .W (EVT_W)
  ) u_evt (
    .i_clk       (I_REF_CLK),
    .i_rst_b     (I_RST_B),
    .i_event     (events),
    .i_wr_status (wr_status),
    .i_wr_mask   (wr_mask),
    .i_wdata     (I_AVS_WRITEDATA[EVT_W-1:0]),
    .o_status    (evt_status),
    .o_mask      (evt_mask),
    .o_irq       (O_EVT_IRQ)
  );

  // outputs straight from flops, except the reset pin value, which is tied low
  assign O_AVS_READDATA    = rdata_q;
  assign O_AVS_WAITREQUEST = wreq_q;
  assign O_LOWVOLT_RESET   = lv_rst_q;
  assign O_RST_PIN_OUT     = 1'b0;
  assign O_RST_PIN_OE      = pin_oe_q;

  // checks
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_B);

  sequence s_low_run;
    I_BELOW_FALLING_TRIP && active && !lv_rst_q;
  endsequence

  chk_reset_cause: assert property (
    $rose(lv_rst_q) |-> $past(rst_hit) || $past(stop_trip))
    else $error("low-voltage reset rose without a filtered or stop trip");

  chk_reset_on_hit: assert property (
    s_low_run ##0 (rst_hit && I_LOWVOLT_RESET_ENABLE) |=> lv_rst_q)
    else $error("filtered low run did not force reset");

  chk_pin_low: assert property (
    lv_rst_q |-> O_RST_PIN_OE && !O_RST_PIN_OUT)
    else $error("reset pin not driven low during forced reset");

  chk_polled_noreset: assert property (
    !I_LOWVOLT_RESET_ENABLE && !lv_rst_q |=> !lv_rst_q)
    else $error("reset raised with reset enable clear");

  chk_power_off: assert property (
    !I_MONITOR_POWER_ENABLE |=> !lv_rst_q && !flag_q)
    else $error("monitor acted with power option clear");

  chk_release_one: assert property (
    lv_rst_q && I_MONITOR_POWER_ENABLE && rst_release |=> !lv_rst_q)
    else $error("reset not released after one good cycle");

  chk_hold_reset: assert property (
    lv_rst_q && I_MONITOR_POWER_ENABLE && !rst_release |=> lv_rst_q)
    else $error("reset released without a good cycle");

  chk_flag_cause: assert property (
    $rose(flag_q) |-> $past(flag_hit) && $past(I_BELOW_FALLING_TRIP))
    else $error("flag set without a filtered low run");

  chk_flag_clear: assert property (
    active && !lv_rst_q && I_ABOVE_RISING_TRIP |=> !flag_q)
    else $error("flag not cleared above rising level");

  chk_stop_bypass: assert property (
    stop_trip && I_MONITOR_POWER_ENABLE && I_LOWVOLT_RESET_ENABLE && !lv_rst_q |=> lv_rst_q)
    else $error("stop trip did not reset at once");

  chk_wait_reset: assert property (
    I_WAIT_MODE && rst_hit && I_LOWVOLT_RESET_ENABLE && active && !lv_rst_q |=> lv_rst_q)
    else $error("filtered trip in wait did not force reset");

  chk_stop_idle: assert property (
    I_STOP_MODE && !I_STOP_MODE_MONITOR_ENABLE && !lv_rst_q |=> !lv_rst_q)
    else $error("monitor acted in stop with stop monitoring clear");

  chk_bus_answer: assert property (
    (I_AVS_READ || I_AVS_WRITE) && bus_q == BUS_IDLE |=> !O_AVS_WAITREQUEST ##1 O_AVS_WAITREQUEST)
    else $error("bus answer not one cycle wide");
endmodule // lvrf_top

// File: verification/lvrf_supply_model.sv
// supply comparator, crystal and cpu cycle source for the low-voltage filter bench.
// assumes one reference clock; the bench moves the supply only through the tasks.
module lvrf_supply_model (
  input  wire logic i_clk,
  output logic      o_below,
  output logic      o_above,
  output logic      o_cpu_cycle,
  output logic      o_xtal
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] xdiv_q = 2'h0;
  // crystal at a quarter rate, safely under the level-sampling limit
  always @(posedge i_clk) begin
    xdiv_q <= xdiv_q + 2'h1;
  end
  assign o_xtal = xdiv_q[1];
  initial begin
    o_below = 1'b0;
    o_above = 1'b1;
    o_cpu_cycle = 1'b0;
  end
  // 0 above rising trip, 1 between trips, 2 below falling trip
  task automatic supply(input int lvl);
    @(posedge i_clk);
    o_below <= (lvl == 2);
    o_above <= (lvl == 0);
  endtask
  // one cpu cycle every second reference cycle
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge i_clk);
      o_cpu_cycle <= 1'b1;
      @(posedge i_clk);
      o_cpu_cycle <= 1'b0;
    end
  endtask
endmodule // lvrf_supply_model

// File: verification/lvrf_top_tb.sv
// self-checking bench for the low-voltage reset filter top.
// assumes the supply model as far side and avalon-mm reads of the status registers.
module lvrf_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lvrf_pkg::*;
  logic              clk = 1'b0;
  logic              rst_b = 1'b0;
  logic              pwr = 1'b1;
  logic              ren = 1'b1;
  logic              smon = 1'b0;
  logic              wmode = 1'b0;
  logic              smode = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic              rd = 1'b0;
  logic              wr = 1'b0;
  logic [DATA_W-1:0] wdata = '0;
  logic [DATA_W-1:0] rdata;
  logic              waitreq, lv_rst, pin_out, pin_oe, irq;
  logic              below, above, cpu, xtal;
  int                fail_count = 0;
  int                total_checks = 0;

  lvrf_top i_lvrf_top (
    .I_REF_CLK                  (clk),
    .I_RST_B                    (rst_b),
    .I_BELOW_FALLING_TRIP       (below),
    .I_ABOVE_RISING_TRIP        (above),
    .I_MONITOR_POWER_ENABLE     (pwr),
    .I_LOWVOLT_RESET_ENABLE     (ren),
    .I_STOP_MODE_MONITOR_ENABLE (smon),
    .I_WAIT_MODE                (wmode),
    .I_STOP_MODE                (smode),
    .I_CPU_CYCLE                (cpu),
    .I_CRYSTAL_CLOCK            (xtal),
    .I_AVS_ADDRESS              (addr),
    .I_AVS_READ                 (rd),
    .I_AVS_WRITE                (wr),
    .I_AVS_WRITEDATA            (wdata),
    .O_AVS_READDATA             (rdata),
    .O_AVS_WAITREQUEST          (waitreq),
    .O_LOWVOLT_RESET            (lv_rst),
    .O_RST_PIN_OUT              (pin_out),
    .O_RST_PIN_OE               (pin_oe),
    .O_EVT_IRQ                  (irq)
  );

  lvrf_supply_model i_lvrf_supply_model (
    .i_clk       (clk),
    .o_below     (below),
    .o_above     (above),
    .o_cpu_cycle (cpu),
    .o_xtal      (xtal)
  );

  // free-running 125 MHz reference
  initial begin
    forever #4 clk = ~clk;
  end

  task automatic complete_run();
    if (fail_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // one avalon transfer; request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [17:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    rd <= !w;
    wr <= w;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 30);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (waitreq !== 1'b0) begin
      fail_count++;
      complete_run();
    end
  endtask

  task automatic rchk(input logic [17:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(what, exp, q);
  endtask

  task automatic wrt(input logic [17:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic flag(input logic f);
    rchk(LV_STATUS_ADDR, {24'h0, f, 7'h0}, "status flag");
  endtask

  // forced reset and the pin pull-down always move together
  task automatic pins(input logic e);
    check("lowvolt reset", {31'h0, e}, {31'h0, lv_rst});
    check("reset pin enable", {31'h0, e}, {31'h0, pin_oe});
    check("reset pin value", 32'h0, {31'h0, pin_out});
  endtask

  task automatic opts(input logic p, input logic r, input logic s, input logic w,
                      input logic st);
    @(posedge clk);
    pwr <= p;
    ren <= r;
    smon <= s;
    wmode <= w;
    smode <= st;
  endtask

  // supply back above rising trip plus one cpu cycle ends a forced reset
  task automatic recover();
    i_lvrf_supply_model.supply(0);
    repeat (3) @(posedge clk);
    pins(1'b1);
    i_lvrf_supply_model.pulses(1);
    repeat (2) @(posedge clk);
    pins(1'b0);
  endtask

  task automatic t_reset();
    pins(1'b0);
    check("irq", 32'h0, {31'h0, irq});
    flag(1'b0);
    rchk(EVT_STATUS_ADDR, 32'h0, "event status");
    rchk(EVT_MASK_ADDR, 32'h0, "event mask");
  endtask

  // a broken run restarts the count; the ninth unbroken low cycle resets
  task automatic t_forced();
    i_lvrf_supply_model.supply(2);
    i_lvrf_supply_model.pulses(5);
    i_lvrf_supply_model.supply(1);
    i_lvrf_supply_model.pulses(1);
    i_lvrf_supply_model.supply(2);
    i_lvrf_supply_model.pulses(8);
    repeat (2) @(posedge clk);
    pins(1'b0);
    i_lvrf_supply_model.pulses(1);
    repeat (2) @(posedge clk);
    pins(1'b1);
    recover();
    flag(1'b0);
  endtask

  task automatic t_events();
    rchk(EVT_STATUS_ADDR, 32'h2, "event status");
    check("irq masked", 32'h0, {31'h0, irq});
    wrt(EVT_MASK_ADDR, 32'h3);
    repeat (2) @(posedge clk);
    check("irq unmasked", 32'h1, {31'h0, irq});
    wrt(EVT_STATUS_ADDR, 32'h2);
    rchk(EVT_STATUS_ADDR, 32'h0, "event cleared");
    check("irq cleared", 32'h0, {31'h0, irq});
    rchk(18'h00008, 32'h0, "unmapped read");
    wrt(LV_STATUS_ADDR, 32'hff);
    flag(1'b0);
  endtask

  // polled use: the flag follows the filtered comparator, no reset
  task automatic t_polled();
    opts(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    i_lvrf_supply_model.supply(2);
    repeat (112) @(posedge clk);
    flag(1'b0);
    i_lvrf_supply_model.pulses(12);
    repeat (160) @(posedge clk);
    pins(1'b0);
    flag(1'b1);
    rchk(EVT_STATUS_ADDR, 32'h1, "flag event");
    i_lvrf_supply_model.supply(1);
    repeat (10) @(posedge clk);
    flag(1'b1);
    i_lvrf_supply_model.supply(0);
    repeat (3) @(posedge clk);
    flag(1'b0);
  endtask

  task automatic t_unpowered();
    opts(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    i_lvrf_supply_model.supply(2);
    i_lvrf_supply_model.pulses(12);
    repeat (200) @(posedge clk);
    pins(1'b0);
    flag(1'b0);
    i_lvrf_supply_model.supply(0);
  endtask

  task automatic t_wait();
    opts(1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
    i_lvrf_supply_model.supply(2);
    i_lvrf_supply_model.pulses(9);
    repeat (2) @(posedge clk);
    pins(1'b1);
    recover();
  endtask

  // stop without stop monitoring is deaf; with it a trip resets unfiltered
  task automatic t_stop();
    opts(1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
    i_lvrf_supply_model.supply(2);
    i_lvrf_supply_model.pulses(12);
    repeat (200) @(posedge clk);
    pins(1'b0);
    flag(1'b0);
    opts(1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
    repeat (3) @(posedge clk);
    pins(1'b1);
    opts(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
    recover();
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_forced();
    t_events();
    t_polled();
    t_unpowered();
    t_wait();
    t_stop();
    complete_run();
  end
endmodule // lvrf_top_tb
